// ==== spcl_pkg.sv ====
package spcl_pkg;
    // control block offsets (low address bits A3..A0)
    localparam logic [3:0] OFF_IRQ_EN = 4'h0;
    localparam logic [3:0] OFF_NVM_LOC = 4'h1;
    localparam logic [3:0] OFF_NVM_DATA = 4'h2;
    localparam logic [3:0] OFF_APPLY = 4'h3;
    // stored layout: channel address bytes then interrupt numbers
    localparam logic [7:0] LOC_ADDR_FIRST = 8'h01;
    localparam logic [7:0] LOC_IRQ_FIRST = 8'h09;
    localparam logic [7:0] LOC_IRQ_SHARED = 8'h0d;
    localparam logic [7:0] LOC_LAST = 8'h0d;
    // channel decode: A9..A3 match, A2..A0 pick a channel register
    localparam int CH_ADDR_LSB = 3;
    localparam int CB_ADDR_LSB = 4;
    localparam int ADDR_MSB = 9;
    // nonvolatile write time
    localparam int CLK_HZ = 50_000_000;
    localparam int NVM_WRITE_US = 2000;
    localparam int NVM_WRITE_CYC = NVM_WRITE_US * (CLK_HZ / 1_000_000);
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_IRQ = 4'h0;
endpackage : spcl_pkg

// ==== spcl_nvm.sv ====
`timescale 1ns/100ps
// ****************************************
// nonvolatile byte store
// ****************************************
module spcl_nvm #(
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // registered read port
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem_r [DEPTH];

    // contents persist across bus reset, so the array is not reset
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    // read data come out of a register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 8'h00;
        end else begin
            rd_data <= mem_r[rd_addr];
        end
    end
endmodule : spcl_nvm

// ==== spcl_loader.sv ====
`timescale 1ns/100ps
// Behaviour
// - offsets 0..3: irq enable, store location, store data, apply config
// - control base from jumpers only; channel bases and irqs from store
// - at power-up stored addresses and irqs copy into port registers
// - a write to offset 3 while idle copies all stored entries to ports
// - irq outputs enable on first channel write or offset-0 write
// - locations 1..8 hold channel A..H address bytes
// - locations 9..C hold irqs A..D; D holds shared irq E..H
// - address byte is A9..A3; channel decode matches that byte
// - irq entry is binary line number; channel irq routed there
// - disable jumper removed: no channel decode, control block still works
// - jumper fitted: channels decode at configured bases
// - data access transfers byte to or from selected location
// - store write takes 2 ms; host waits before next access
// - control base compares A9..A4 to jumpers, fitted reads as 0
module spcl_loader #(
    parameter int NCH = 8,
    parameter int NIRQ = 16,
    parameter int WRITE_CYC = spcl_pkg::NVM_WRITE_CYC
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RSTN,
    // host i/o bus
    input wire logic [9:0] ADDR,
    input wire logic IOW,
    input wire logic IOR,
    input wire logic [7:0] DIN,
    output logic [7:0] DOUT,
    output logic DOUT_EN,
    // jumpers: a fitted jumper reads 0
    input wire logic [5:0] ADDR_JUMPER,
    input wire logic PORT_DISABLE_JUMPER,
    // per-channel interrupts from the uarts
    input wire logic [NCH-1:0] CH_IRQ,
    // decode and routing outputs
    output logic [NCH-1:0] CH_SEL,
    output logic [NIRQ-1:0] IRQ_LINE,
    output logic BUSY
);
    typedef enum logic [1:0] {
        SPCL_IDLE = 2'b00,
        SPCL_LOAD = 2'b01,
        SPCL_WRITE = 2'b10
    } spcl_state_e;

    spcl_state_e state_r;
    logic [7:0] loc_r;
    logic [3:0] ld_ptr_r;
    logic ld_valid_r;
    logic [3:0] rd_ptr;
    logic [7:0] nvm_q;
    logic [7:0] ch_base_r [NCH];
    logic [3:0] ch_irq_r [NCH];
    logic irq_en_r;
    logic loaded_r;
    logic [$clog2(WRITE_CYC+1)-1:0] wcnt_r;
    logic cb_hit;
    logic any_ch_hit;
    logic nvm_wr;
    logic apply_req;
    logic [NCH-1:0] ch_hit;

    // ****************************************
    // control block decode
    // ****************************************
    // base compare on A9..A4; A3..A0 pick the register
    assign cb_hit = (ADDR[9:4] == ADDR_JUMPER)
        && (ADDR[3:2] == 2'b00);
    assign nvm_wr = cb_hit && IOW && (ADDR[3:0] == spcl_pkg::OFF_NVM_DATA)
        && (state_r == SPCL_IDLE);
    assign apply_req = cb_hit && IOW
        && (ADDR[3:0] == spcl_pkg::OFF_APPLY);

    // store location register
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            loc_r <= spcl_pkg::RST_BYTE;
        end else if (cb_hit && IOW
                     && ADDR[3:0] == spcl_pkg::OFF_NVM_LOC) begin
            loc_r <= DIN;
        end
    end

    // read of the data offset returns the selected byte
    assign DOUT = nvm_q;
    assign DOUT_EN = cb_hit && IOR && (ADDR[3:0] == spcl_pkg::OFF_NVM_DATA)
        && (state_r == SPCL_IDLE);

    // ****************************************
    // store and loader sequencer
    // ****************************************
    assign rd_ptr = (state_r == SPCL_LOAD) ? ld_ptr_r : loc_r[3:0];

    spcl_nvm #(.DEPTH(16), .AW(4)) u_nvm (
        .clk(CLK_SYS),
        .rst_n(RSTN),
        .wr_en(nvm_wr),
        .wr_addr(loc_r[3:0]),
        .wr_data(DIN),
        .rd_addr(rd_ptr),
        .rd_data(nvm_q)
    );

    // load walks locations 1..D; data lag the pointer by one cycle
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            state_r <= SPCL_LOAD;
            ld_ptr_r <= spcl_pkg::LOC_ADDR_FIRST[3:0];
            ld_valid_r <= 1'b0;
            wcnt_r <= '0;
        end else begin
            unique case (state_r)
                SPCL_IDLE: begin
                    ld_valid_r <= 1'b0;
                    if (nvm_wr) begin
                        state_r <= SPCL_WRITE;
                        wcnt_r <= '0;
                    end else if (apply_req) begin
                        state_r <= SPCL_LOAD;
                        ld_ptr_r <= spcl_pkg::LOC_ADDR_FIRST[3:0];
                    end
                end
                SPCL_LOAD: begin
                    ld_valid_r <= 1'b1;
                    if (ld_ptr_r == spcl_pkg::LOC_LAST[3:0]) begin
                        state_r <= SPCL_IDLE;
                    end else begin
                        ld_ptr_r <= ld_ptr_r + 4'h1;
                    end
                end
                SPCL_WRITE: begin
                    // the store ignores the bus while it programs
                    if (wcnt_r == WRITE_CYC[$bits(wcnt_r)-1:0] - 1'b1) begin
                        state_r <= SPCL_IDLE;
                    end else begin
                        wcnt_r <= wcnt_r + 1'b1;
                    end
                end
                // unused code 11: fall back to idle rather than hang
                default: begin
                    state_r <= SPCL_IDLE;
                end
            endcase
        end
    end

    // pointer of the byte now on nvm_q during a load
    logic [3:0] ld_prev_r;
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            ld_prev_r <= 4'h0;
        end else begin
            ld_prev_r <= ld_ptr_r;
        end
    end

    // port registers take the walked bytes
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            for (int i = 0; i < NCH; i++) begin
                ch_base_r[i] <= spcl_pkg::RST_BYTE;
                ch_irq_r[i] <= spcl_pkg::RST_IRQ;
            end
        end else if (ld_valid_r) begin
            for (int i = 0; i < NCH; i++) begin
                if (ld_prev_r == 4'(i + 1)) begin
                    ch_base_r[i] <= nvm_q;
                end
                if (i < 4 && ld_prev_r == 4'(i + 9)) begin
                    ch_irq_r[i] <= nvm_q[3:0];
                end
                if (i >= 4 && ld_prev_r == spcl_pkg::LOC_IRQ_SHARED[3:0]) begin
                    ch_irq_r[i] <= nvm_q[3:0];
                end
            end
        end
    end

    // first completed load opens channel decode
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            loaded_r <= 1'b0;
        end else if (ld_valid_r && state_r == SPCL_IDLE) begin
            loaded_r <= 1'b1;
        end
    end

    // ****************************************
    // channel decode and interrupt routing
    // ****************************************
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            ch_hit[i] = (ADDR[9:3] == ch_base_r[i][6:0]) && loaded_r
                && !PORT_DISABLE_JUMPER;
        end
    end
    assign CH_SEL = ch_hit;
    assign any_ch_hit = |ch_hit;

    // irq enable latches on first channel write or command
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            irq_en_r <= 1'b0;
        end else if ((any_ch_hit && IOW) || (cb_hit && IOW
                     && ADDR[3:0] == spcl_pkg::OFF_IRQ_EN)) begin
            irq_en_r <= 1'b1;
        end
    end

    // route each channel to its numbered line, registered
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            IRQ_LINE <= '0;
        end else begin
            logic [NIRQ-1:0] acc;
            acc = '0;
            for (int i = 0; i < NCH; i++) begin
                if (CH_IRQ[i] && irq_en_r && loaded_r) begin
                    acc[ch_irq_r[i]] = 1'b1;
                end
            end
            IRQ_LINE <= acc;
        end
    end

    assign BUSY = (state_r != SPCL_IDLE);

    // ****************************************
    // checks
    // ****************************************
    sequence s_apply;
        (state_r == SPCL_IDLE) && apply_req;
    endsequence

    a_apply_loads: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        s_apply |=> (state_r == SPCL_LOAD) [*8])
        else $error("apply did not start a load");
    a_write_busy: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        nvm_wr |=> BUSY [*8])
        else $error("store write did not hold busy");
    a_disable_decode: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        PORT_DISABLE_JUMPER |-> CH_SEL == '0)
        else $error("channel decoded while disabled");
    a_no_early_dec: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        !loaded_r |-> CH_SEL == '0)
        else $error("channel decoded before load");
    a_powerup_load: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        $rose(RSTN) |-> ##[1:20] loaded_r)
        else $error("power-up load did not finish");
    a_irq_enable: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (any_ch_hit && IOW) |=> irq_en_r)
        else $error("channel write left irqs off");
    a_loc_select: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (cb_hit && IOW && ADDR[3:0] == spcl_pkg::OFF_NVM_LOC)
        |=> loc_r == $past(DIN))
        else $error("location not taken");
    a_ch_match: assert property (@(posedge CLK_SYS) disable iff (!RSTN)
        (loaded_r && !PORT_DISABLE_JUMPER && ADDR[9:3] == ch_base_r[0][6:0])
        |-> CH_SEL[0])
        else $error("channel A missed its base");
endmodule : spcl_loader

// ==== spcl_host_model.sv ====
`timescale 1ns/100ps
// ****************************************
// host processor on the i/o bus
// ****************************************
module spcl_host_model (
    // clock and board status
    input wire logic clk,
    input wire logic busy,
    input wire logic [7:0] dout,
    input wire logic dout_en,
    // bus drive
    output logic [9:0] addr,
    output logic iow,
    output logic ior,
    output logic [7:0] din,
    // raised when a bounded wait ran out
    output logic hung
);
    initial begin
        addr = 10'h000;
        iow = 1'b0;
        ior = 1'b0;
        din = 8'h00;
        hung = 1'b0;
    end
    // never touch the board while a load or store write runs
    task automatic idle();
        int n;
        n = 0;
        #1;
        while (busy !== 1'b0 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 200) hung <= 1'b1;
    endtask : idle
    // one-cycle write strobe; data line shows junk once released
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        idle();
        @(posedge clk);
        addr <= a;
        din <= d;
        iow <= 1'b1;
        @(posedge clk);
        iow <= 1'b0;
        din <= ~d;
    endtask : wr
    // read held two edges: data is registered behind the location
    task automatic rd(input logic [9:0] a, output logic [7:0] d,
                      output logic en);
        idle();
        @(posedge clk);
        addr <= a;
        ior <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        d = dout;
        en = dout_en;
        ior <= 1'b0;
    endtask : rd
    // location first, then the byte
    task automatic store(input logic [9:0] cb, input logic [7:0] loc,
                         input logic [7:0] d);
        wr(cb + 10'h1, loc);
        wr(cb + 10'h2, d);
    endtask : store
    // park the address bus without a strobe
    task automatic probe(input logic [9:0] a);
        @(posedge clk);
        addr <= a;
    endtask : probe
endmodule : spcl_host_model

// ==== spcl_loader_tb_top.sv ====
`timescale 1ns/100ps
// ****************************************
// loader testbench
// ****************************************
module spcl_loader_tb_top;
    localparam logic [9:0] CB = 10'h200; // a9 jumper absent, rest fitted
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic jmp_dis = 1'b0;
    logic [7:0] ch_irq = 8'h00;
    logic [9:0] addr;
    logic iow, ior, dout_en, busy, hung;
    logic [7:0] din, dout, ch_sel, rd_d;
    logic [15:0] irq_line;
    logic rd_en;
    int err_total = 0;
    int n_compared = 0;
    // 50 mhz system clock
    always #10 clk_sys = ~clk_sys;
    spcl_loader #(.WRITE_CYC(16)) spcl_loader_inst (
        .CLK_SYS(clk_sys), .RSTN(rstn), .ADDR(addr), .IOW(iow), .IOR(ior),
        .DIN(din), .DOUT(dout), .DOUT_EN(dout_en),
        .ADDR_JUMPER(6'b100000), .PORT_DISABLE_JUMPER(jmp_dis),
        .CH_IRQ(ch_irq), .CH_SEL(ch_sel), .IRQ_LINE(irq_line), .BUSY(busy)
    );
    spcl_host_model spcl_host_model_inst (
        .clk(clk_sys), .busy(busy), .dout(dout), .dout_en(dout_en),
        .addr(addr), .iow(iow), .ior(ior), .din(din), .hung(hung)
    );
    task automatic chk(input string nm, input logic [15:0] seen, exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : end_sim
    // a hung wait is a failure of its own
    always @(posedge hung) begin
        err_total++;
        end_sim();
    end
    // reset; the power-up load must keep channels quiet meanwhile
    task automatic do_reset();
        @(posedge clk_sys);
        rstn <= 1'b0;
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("ch_sel in load", 16'(ch_sel), 16'h0);
        spcl_host_model_inst.idle();
    endtask : do_reset
    // channel i lives at 300 + 8*i; a2..a0 must not matter
    task automatic chk_map(input logic en);
        // a running load rewrites the bases; let it finish first
        spcl_host_model_inst.idle();
        for (int i = 0; i < 8; i++) begin
            spcl_host_model_inst.probe(10'h303 + 10'(8 * i));
            #1;
            chk("ch_sel", 16'(ch_sel), en ? 16'(1 << i) : 16'h0);
        end
    endtask : chk_map
    // a..d on lines 3..6, e..h share line 7
    task automatic chk_irq(input logic en);
        for (int i = 0; i < 8; i++) begin
            @(posedge clk_sys);
            ch_irq <= 8'(1 << i);
            repeat (2) @(posedge clk_sys);
            #1;
            chk("irq_line", irq_line,
                en ? 16'(1 << (i < 4 ? 3 + i : 7)) : 16'h0);
        end
        @(posedge clk_sys);
        ch_irq <= 8'h00;
    endtask : chk_irq
    initial begin
        do_reset();
        for (int i = 1; i <= 13; i++)
            spcl_host_model_inst.store(CB, 8'(i), i <= 8 ? 8'h5f + 8'(i)
                : (i < 13 ? 8'(i - 6) : 8'h07));
        spcl_host_model_inst.wr(CB + 10'h1, 8'h0b);
        spcl_host_model_inst.rd(CB + 10'h2, rd_d, rd_en);
        chk("nvm data", 16'(rd_d), 16'h05);
        chk("dout_en", 16'(rd_en), 16'h1);
        spcl_host_model_inst.wr(CB + 10'h3, 8'ha5);
        chk_map(1'b1);
        chk_irq(1'b0);
        spcl_host_model_inst.wr(10'h300, 8'h00);
        chk_irq(1'b1);
        $display("test program apply irq done");
        do_reset();
        chk_map(1'b1);
        chk_irq(1'b0);
        spcl_host_model_inst.wr(CB, 8'h01);
        chk_irq(1'b1);
        $display("test power-up load done");
        spcl_host_model_inst.wr(10'h212, 8'h00);
        @(posedge clk_sys);
        #1;
        chk("busy off base", 16'(busy), 16'h0);
        @(posedge clk_sys);
        jmp_dis <= 1'b1;
        chk_map(1'b0);
        spcl_host_model_inst.wr(CB + 10'h1, 8'h02);
        spcl_host_model_inst.rd(CB + 10'h2, rd_d, rd_en);
        chk("nvm data dis", 16'(rd_d), 16'h61);
        @(posedge clk_sys);
        jmp_dis <= 1'b0;
        chk_map(1'b1);
        $display("test jumpers done");
        end_sim();
    end
endmodule : spcl_loader_tb_top
